/* dv/csri_mem_model.sv */
// Purpose: Behavioural memory on one port of the core memory interface.
// Assumes: Read word is the inverted address; stall length set by the bench.
// Notes: Lanes not returned carry a pattern that moves every cycle.
`timescale 1ns/1ps
`default_nettype none
module csri_mem_model
  import csri_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Port from the core
  input wire csri_req_type req,
  input wire logic abort,
  // Bench controls
  input wire logic [3:0] stall_cyc,
  input wire logic narrow,
  input wire logic ack_en,
  // Answer
  output csri_rsp_type rsp
);
  logic [3:0] cnt_q;
  logic [7:0] ph_q;
  logic [3:0] last;
  ////////////////////////////////////////////////////////////////////////////
  // Counts stall cycles of the standing transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      ph_q <= 8'h00;
    end else begin
      ph_q <= ph_q + 8'h01;
      if (req.valid && rsp.stall && !rsp.abort_ack) cnt_q <= cnt_q + 4'h1;
      else cnt_q <= 4'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Stall, abort answer and lane steering
  assign last = narrow ? 4'h3 : stall_cyc;
  always_comb begin
    rsp.stall = req.valid && (cnt_q < last);
    rsp.abort_ack = ack_en && abort;
    rsp.rbe = 4'h0;
    if (req.valid && narrow) rsp.rbe = 4'h1 << cnt_q[1:0];
    else if (req.valid && !rsp.stall) rsp.rbe = 4'hF;
    for (int i = 0; i < 4; i++) begin
      rsp.rdata[8*i+:8] = rsp.rbe[i] ? ~req.addr[8*i+:8] : ph_q ^ 8'h5A;
    end
  end
endmodule
`default_nettype wire

/* dv/csri_top_tb.sv */
// Purpose: Self-checking bench of the core memory interface, dual build.
// Assumes: Two memory models answer the fetch and data ports.
// Notes: Read words are the inverted address.
`timescale 1ns/1ps
`default_nettype none
`include "csri_defines.svh"
module csri_top_tb
  import csri_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, i_crdata, d_crdata;
  logic warm_reset_in = 0, cold_reset_in = 0, nmi_in = 0, data_redirect_request = 0;
  logic ack_en = 0, i_nar = 0, d_nar = 0;
  logic [5:0] irq_in = 6'h00;
  logic [3:0] i_stall = 4'h0, d_stall = 4'h0;
  logic pready, pslverr, reset_exception_out, sleep_out, reduced_power_out;
  logic exception_level_out, error_level_out, debug_mode_out;
  logic i_cready, i_cdone, d_cready, d_cdone, iport_abort, dport_abort, both_seen = 0;
  logic ia_seen = 0;
  csri_req_type i_creq = '0, d_creq = '0, iport_req, dport_req, ilast, dlast;
  csri_rsp_type iport_rsp, dport_rsp;
  int errors = 0, checks_done = 0, rex_n = 0, dd_n = 0;

  // Device and its two memories
  csri_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .warm_reset_in, .cold_reset_in, .irq_in, .nmi_in,
    .reset_exception_out, .sleep_out, .reduced_power_out, .exception_level_out,
    .error_level_out, .debug_mode_out, .i_creq, .i_cready, .i_cdone, .i_crdata,
    .d_creq, .d_cready, .d_cdone, .d_crdata, .iport_req, .iport_rsp, .iport_abort,
    .dport_req, .dport_rsp, .dport_abort, .data_redirect_request);
  csri_mem_model mi (.pclk, .presetn, .req(iport_req), .abort(iport_abort),
    .stall_cyc(i_stall), .narrow(i_nar), .ack_en, .rsp(iport_rsp));
  csri_mem_model md (.pclk, .presetn, .req(dport_req), .abort(dport_abort),
    .stall_cyc(d_stall), .narrow(d_nar), .ack_en, .rsp(dport_rsp));

  // Clock
  always #4 pclk = ~pclk;

  // Port monitor: last request per port, overlap, pulse counts
  always @(negedge pclk) begin
    if (iport_req.valid === 1'b1) ilast <= iport_req;
    if (dport_req.valid === 1'b1) dlast <= dport_req;
    if (iport_req.valid === 1'b1 && dport_req.valid === 1'b1) both_seen <= 1'b1;
    if (iport_abort === 1'b1) ia_seen <= 1'b1;
    if (reset_exception_out === 1'b1) rex_n++;
    if (d_cdone === 1'b1) dd_n++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("Mismatches %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // APB master, pipeline and reset pulse drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, wd, q, e);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, exp);
  endtask
  function automatic csri_req_type rq(logic [31:0] a, logic w, logic lk, logic sy, logic cl);
    rq = '0;
    rq.valid = 1'b1;
    rq.write = w;
    rq.lock = lk;
    rq.sync = sy;
    rq.call = cl;
    rq.be = 4'hF;
    rq.addr = a;
    rq.wdata = ~a;
  endfunction
  task automatic pipe(input logic d, input csri_req_type r, input logic c);
    int n;
    @(posedge pclk);
    if (d) d_creq <= r;
    else i_creq <= r;
    n = 0;
    do begin @(posedge pclk); n++; end while ((d ? d_cready : i_cready) !== 1'b1 && n < 50);
    if (d) d_creq.valid <= 1'b0;
    else i_creq.valid <= 1'b0;
    n = 0;
    do begin @(posedge pclk); n++; end while ((d ? d_cdone : i_cdone) !== 1'b1 && n < 80);
    chk1(d ? d_cdone : i_cdone, 1'b1);
    if (c) chk(d ? d_crdata : i_crdata, ~r.addr);
  endtask
  task automatic rpulse(input logic c, input int len, input int exp);
    int n0;
    n0 = rex_n;
    @(posedge pclk);
    if (c) cold_reset_in <= 1'b1;
    else warm_reset_in <= 1'b1;
    repeat (len) @(posedge pclk);
    cold_reset_in <= 1'b0;
    warm_reset_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(rex_n - n0, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rdm(`CSRI_OFS_STATUS, 32'hFFFF_FFFF, `CSRI_STATUS_RST);
    rdm(`CSRI_OFS_STATE, 32'h0000_003F, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(`CSRI_OFS_STATUS, 32'h0800_0006);
    wr(`CSRI_OFS_DEBUG, 32'h4000_0000);
    repeat (2) @(negedge pclk);
    chk({reduced_power_out, exception_level_out, error_level_out, debug_mode_out},
        4'hF);
    wr(`CSRI_OFS_STATUS, 32'h0000_0002);
    wr(`CSRI_OFS_DEBUG, 32'h0);
    repeat (2) @(negedge pclk);
    chk({reduced_power_out, exception_level_out, error_level_out, debug_mode_out},
        4'h4);
    wr(`CSRI_OFS_STATUS, 32'h0);
  endtask
  task automatic t_port;
    @(posedge pclk);
    i_stall <= 4'h2;
    d_stall <= 4'h1;
    fork
      pipe(1'b0, rq(32'h0000_1000, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
      pipe(1'b1, rq(32'h0000_2004, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
    join
    chk1(both_seen, 1'b1);
    @(posedge pclk);
    i_nar <= 1'b1;
    d_nar <= 1'b1;
    fork
      pipe(1'b0, rq(32'hC3A5_0F18, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
      pipe(1'b1, rq(32'h3C5A_F0E4, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
    join
    @(posedge pclk);
    i_nar <= 1'b0;
    d_nar <= 1'b0;
    pipe(1'b0, rq(32'h0000_1100, 1'b0, 1'b0, 1'b0, 1'b1), 1'b1);
    chk1(ilast.call, 1'b1);
    pipe(1'b1, rq(32'h0000_2200, 1'b0, 1'b1, 1'b0, 1'b0), 1'b1);
    chk1(dlast.lock, 1'b1);
    pipe(1'b1, rq(32'h0000_2300, 1'b1, 1'b0, 1'b1, 1'b0), 1'b0);
    chk({dlast.lock, dlast.sync, dlast.write}, 3'b011);
    chk(dlast.wdata, 32'hFFFF_DCFF);
    @(posedge pclk);
    data_redirect_request <= 1'b1;
    pipe(1'b1, rq(32'h0000_2408, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
    chk(ilast.addr, 32'h0000_2408);
    @(posedge pclk);
    data_redirect_request <= 1'b0;
  endtask
  task automatic t_abort;
    int n0;
    @(posedge pclk);
    d_stall <= 4'hF;
    ack_en <= 1'b1;
    fork
      pipe(1'b1, rq(32'h0000_3000, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
      begin
        repeat (4) @(posedge pclk);
        irq_in <= 6'h04;
        @(negedge pclk);
        chk1(dport_abort, 1'b1);
        n0 = dd_n;
        repeat (10) @(posedge pclk);
        chk(dd_n, n0);
        d_stall <= 4'h0;
        irq_in <= 6'h00;
      end
    join
    @(posedge pclk);
    ack_en <= 1'b0;
    d_stall <= 4'h3;
    irq_in <= 6'h01;
    fork
      pipe(1'b1, rq(32'h0000_3104, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
      pipe(1'b0, rq(32'h0000_3208, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
    join
    chk1(ia_seen, 1'b1);
    @(posedge pclk);
    irq_in <= 6'h00;
    d_stall <= 4'h0;
  endtask
  task automatic t_reset;
    rpulse(1'b0, 4, 0);
    rpulse(1'b0, 5, 1);
    rdm(`CSRI_OFS_STATUS, 32'h0010_0000, 32'h0010_0000);
    rpulse(1'b1, 5, 1);
    rdm(`CSRI_OFS_STATUS, 32'h0010_0000, 32'h0);
    wr(`CSRI_OFS_DEBUG, 32'h4000_0001);
    rpulse(1'b0, 5, 0);
    rpulse(1'b1, 5, 1);
    wr(`CSRI_OFS_DEBUG, 32'h0);
  endtask
  task automatic t_sleep;
    for (int k = 0; k < 3; k++) begin
      wr(`CSRI_OFS_WAIT, 32'h1);
      repeat (2) @(negedge pclk);
      chk1(sleep_out, 1'b1);
      chk1(i_cready, 1'b0);
      rdm(`CSRI_OFS_WAIT, 32'h0000_0001, 32'h0000_0001);
      @(posedge pclk);
      if (k == 0) irq_in <= 6'h20;
      else if (k == 1) nmi_in <= 1'b1;
      else warm_reset_in <= 1'b1;
      repeat (3) @(negedge pclk);
      chk1(sleep_out, 1'b0);
      @(posedge pclk);
      irq_in <= 6'h00;
      nmi_in <= 1'b0;
      warm_reset_in <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_port;
    t_abort;
    t_reset;
    t_sleep;
    print_verdict;
  end
  initial begin
    #300000;
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire

/* rtl/csri_defines.svh */
// Purpose: Offsets, field positions, reset values and counts of the core memory interface.
// Assumes: APB byte addresses, 32-bit registers on aligned words.
// Notes: Definitions only.
`ifndef CSRI_DEFINES_SVH
`define CSRI_DEFINES_SVH

// Register byte offsets
`define CSRI_OFS_STATUS 8'h00
`define CSRI_OFS_DEBUG 8'h04
`define CSRI_OFS_WAIT 8'h08
`define CSRI_OFS_STATE 8'h0C

// Status register fields
`define CSRI_EXL_BIT 1
`define CSRI_ERL_BIT 2
`define CSRI_SR_BIT 20
`define CSRI_RP_BIT 27
`define CSRI_STATUS_RST 32'h0000_0000
`define CSRI_STATUS_WMASK 32'h0810_0006

// Debug register fields
`define CSRI_WMASK_BIT 0
`define CSRI_DM_BIT 30
`define CSRI_DEBUG_RST 32'h0000_0000
`define CSRI_DEBUG_WMASK 32'h4000_0001

// Wait register field
`define CSRI_SLEEP_BIT 0

// Least reset pulse, in core clock cycles
`define CSRI_RST_MIN_CYC 3'h5

`endif

/* rtl/csri_lane_cap.sv */
// Purpose: Gathers a read word byte by byte from partial returns.
// Assumes: Byte enables mark valid lanes in any cycle of a transfer.
// Notes: Read word comes out of a register, loaded on the final cycle.
`timescale 1ns/1ps
`default_nettype none
module csri_lane_cap
  import csri_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic en,
  input wire logic fin,
  // Lanes in
  input wire logic [3:0] be,
  input wire logic [31:0] din,
  // Word out
  output logic [31:0] dout
);

  logic [31:0] acc_q;
  logic [31:0] merged;

  ////////////////////////////////////////////////////////////////////////////
  // One lane per byte
  for (genvar b = 0; b < 4; b++) begin : g_lane
    // Take flagged byte, else keep gathered one
    assign merged[8*b+:8] = (en && be[b]) ? din[8*b+:8] : acc_q[8*b+:8];

    // Gathered byte store
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_q[8*b+:8] <= 8'h00;
      end else if (clr) begin
        acc_q[8*b+:8] <= 8'h00;
      end else begin
        acc_q[8*b+:8] <= merged[8*b+:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Whole word registered at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 32'h0000_0000;
    end else if (fin) begin
      dout <= merged;
    end
  end

endmodule
`default_nettype wire

/* rtl/csri_pkg.sv */
// Purpose: Types shared by the core memory interface files.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Requests travel as one packed struct, answers as another.
package csri_pkg;

  // One memory request, as the pipeline gives it and a port shows it
  typedef struct packed {
    logic valid;
    logic write;
    logic lock;
    logic sync;
    logic call;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } csri_req_type;

  // What a memory port returns
  typedef struct packed {
    logic stall;
    logic abort_ack;
    logic [3:0] rbe;
    logic [31:0] rdata;
  } csri_rsp_type;

  // Fetch engine states
  typedef enum logic [1:0] {I_IDLE, I_WAIT, I_PORT, I_HELD} csri_ist_type;

  // Data engine states
  typedef enum logic [2:0] {D_IDLE, D_DPORT, D_WAIT_I, D_IPORT, D_HELD} csri_dst_type;

endpackage

/* rtl/csri_top.sv */
// Purpose: Core side of the tightly coupled memory interface, reset and power pins.
// Assumes: Pins synchronous to pclk; registers reached over APB.
// Notes: UNIFIED selects one shared port; dport then stays idle.
`timescale 1ns/1ps
`default_nettype none
`include "csri_defines.svh"
module csri_top
  import csri_pkg::*;
#(
  parameter bit UNIFIED = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System pins
  input wire logic warm_reset_in,
  input wire logic cold_reset_in,
  input wire logic [5:0] irq_in,
  input wire logic nmi_in,
  output logic reset_exception_out,
  output logic sleep_out,
  output logic reduced_power_out,
  output logic exception_level_out,
  output logic error_level_out,
  output logic debug_mode_out,
  // Pipeline fetch side
  input wire csri_req_type i_creq,
  output logic i_cready,
  output logic i_cdone,
  output logic [31:0] i_crdata,
  // Pipeline data side
  input wire csri_req_type d_creq,
  output logic d_cready,
  output logic d_cdone,
  output logic [31:0] d_crdata,
  // Fetch (or shared) memory port
  output csri_req_type iport_req,
  input wire csri_rsp_type iport_rsp,
  output logic iport_abort,
  // Data memory port
  output csri_req_type dport_req,
  input wire csri_rsp_type dport_rsp,
  output logic dport_abort,
  input wire logic data_redirect_request
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  csri_ist_type i_st_q;
  csri_dst_type d_st_q;
  csri_req_type i_lat_q, d_lat_q;
  logic [31:0] status_q, debug_q, rd_d;
  logic [2:0] rcnt_q;
  logic cold_seen_q, exc_q, sleep_q, i_done_q, d_done_q;
  logic intr, warm_eff, rst_comb, exc_d, hit, wr_en;
  logic i_on, d_on_i, d_on_d, i_acc, d_acc, redir_now, gnt_i, gnt_d;
  logic ip_ack, ip_fin, dp_ack, dp_fin, i_fin, d_fin, i_ack, d_ack;
  logic d_en;

  ////////////////////////////////////////////////////////////////////////////
  // Reset combining and masking
  assign warm_eff = warm_reset_in &&
                    !(debug_q[`CSRI_DM_BIT] && debug_q[`CSRI_WMASK_BIT]);
  assign rst_comb = cold_reset_in || warm_eff;
  assign exc_d = !rst_comb && (rcnt_q == `CSRI_RST_MIN_CYC);
  assign intr = (|irq_in) || nmi_in;

  // Reset length count and cold-reset memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_q <= 3'h0;
      cold_seen_q <= 1'b0;
    end else if (rst_comb) begin
      if (rcnt_q != `CSRI_RST_MIN_CYC) begin
        rcnt_q <= rcnt_q + 3'h1;
      end
      cold_seen_q <= (rcnt_q == 3'h0) ? cold_reset_in : (cold_seen_q || cold_reset_in);
    end else begin
      rcnt_q <= 3'h0;
    end
  end

  // Reset exception pulse one cycle after the falling edge of a reset held at least 5 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_q <= 1'b0;
    end else begin
      exc_q <= exc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; always ready, unmapped answers with an error
  assign pready = 1'b1;
  assign hit = (paddr == `CSRI_OFS_STATUS) || (paddr == `CSRI_OFS_DEBUG) ||
               (paddr == `CSRI_OFS_WAIT) || (paddr == `CSRI_OFS_STATE);
  assign pslverr = psel && penable && !hit;
  assign wr_en = psel && penable && pwrite && hit;

  // Read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      `CSRI_OFS_STATUS: rd_d = status_q;
      `CSRI_OFS_DEBUG: rd_d = debug_q;
      `CSRI_OFS_WAIT: rd_d[`CSRI_SLEEP_BIT] = sleep_q;
      `CSRI_OFS_STATE: rd_d[5:0] = {UNIFIED, rst_comb, d_st_q == D_HELD,
                                    i_st_q == I_HELD, d_st_q != D_IDLE, i_st_q != I_IDLE};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // Status register; soft reset flag set wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `CSRI_STATUS_RST;
    end else begin
      if (wr_en && paddr == `CSRI_OFS_STATUS) begin
        status_q <= pwdata & `CSRI_STATUS_WMASK;
      end
      if (exc_d) begin
        status_q[`CSRI_SR_BIT] <= !cold_seen_q;
      end
    end
  end

  // Debug register: mode bit and warm-mask request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_q <= `CSRI_DEBUG_RST;
    end else if (wr_en && paddr == `CSRI_OFS_DEBUG) begin
      debug_q <= pwdata & `CSRI_DEBUG_WMASK;
    end
  end

  // Power pins follow their bits
  assign reduced_power_out = status_q[`CSRI_RP_BIT];
  assign exception_level_out = status_q[`CSRI_EXL_BIT];
  assign error_level_out = status_q[`CSRI_ERL_BIT];
  assign debug_mode_out = debug_q[`CSRI_DM_BIT];

  // Wait sleep: wake on interrupt, NMI or reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (rst_comb || intr) begin
      sleep_q <= 1'b0;
    end else if (wr_en && paddr == `CSRI_OFS_WAIT && pwdata[`CSRI_SLEEP_BIT]) begin
      sleep_q <= 1'b1;
    end
  end
  assign sleep_out = sleep_q;
  assign reset_exception_out = exc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance; nothing new while asleep or in reset
  assign i_cready = (i_st_q == I_IDLE) && !sleep_q && !rst_comb;
  assign d_cready = (d_st_q == D_IDLE) && !sleep_q && !rst_comb;
  assign i_acc = i_creq.valid && i_cready;
  assign d_acc = d_creq.valid && d_cready;

  // Latched requests; fetches carry the call mark, data carries lock and sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_lat_q <= '0;
      d_lat_q <= '0;
    end else begin
      if (i_acc) begin
        i_lat_q <= '{valid: 1'b1, write: 1'b0, lock: 1'b0, sync: 1'b0,
                     call: i_creq.call, be: 4'hF, addr: i_creq.addr,
                     wdata: 32'h0000_0000};
      end
      if (d_acc) begin
        d_lat_q <= d_creq;
        d_lat_q.valid <= 1'b1;
        d_lat_q.call <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port occupancy and grants for the fetch port
  assign i_on = (i_st_q == I_PORT);
  assign d_on_i = (d_st_q == D_IPORT);
  assign d_on_d = (d_st_q == D_DPORT);
  assign redir_now = !UNIFIED && d_on_d && data_redirect_request;
  assign gnt_d = (d_st_q == D_WAIT_I) && !i_on;
  assign gnt_i = (i_st_q == I_WAIT) && !d_on_i && (d_st_q != D_WAIT_I) &&
                 !redir_now;

  // Port drive; separate 32-bit address, write and read buses
  assign iport_req = d_on_i ? d_lat_q : (i_on ? i_lat_q : '0);
  assign dport_req = d_on_d ? d_lat_q : '0;
  assign iport_abort = iport_req.valid && intr;
  assign dport_abort = dport_req.valid && intr;

  // Completion and acknowledged abort per port
  assign ip_ack = iport_abort && iport_rsp.abort_ack;
  assign dp_ack = dport_abort && dport_rsp.abort_ack;
  assign ip_fin = iport_req.valid && !iport_rsp.stall && !ip_ack;
  assign dp_fin = dport_req.valid && !dport_rsp.stall && !dp_ack && !redir_now;
  assign i_fin = i_on && ip_fin;
  assign i_ack = i_on && ip_ack;
  assign d_fin = (d_on_i && ip_fin) || (d_on_d && dp_fin);
  assign d_ack = (d_on_i && ip_ack) || (d_on_d && dp_ack);

  ////////////////////////////////////////////////////////////////////////////
  // Fetch engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_st_q <= I_IDLE;
    end else if (rst_comb) begin
      i_st_q <= I_IDLE;
    end else begin
      unique case (i_st_q)
        I_IDLE: if (i_acc) begin
          i_st_q <= I_WAIT;
        end
        I_WAIT: if (gnt_i) begin
          i_st_q <= I_PORT;
        end
        I_PORT: if (i_ack) begin
          i_st_q <= I_HELD;
        end else if (i_fin) begin
          i_st_q <= I_IDLE;
        end
        I_HELD: if (!intr) begin
          i_st_q <= I_WAIT;
        end
      endcase
    end
  end

  // Data engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_st_q <= D_IDLE;
    end else if (rst_comb) begin
      d_st_q <= D_IDLE;
    end else begin
      unique case (d_st_q)
        D_IDLE: if (d_acc) begin
          d_st_q <= UNIFIED ? D_WAIT_I : D_DPORT;
        end
        D_DPORT: if (d_ack) begin
          d_st_q <= D_HELD;
        end else if (redir_now) begin
          d_st_q <= i_on ? D_WAIT_I : D_IPORT;
        end else if (d_fin) begin
          d_st_q <= D_IDLE;
        end
        D_WAIT_I: if (gnt_d) begin
          d_st_q <= D_IPORT;
        end
        D_IPORT: if (d_ack) begin
          d_st_q <= D_HELD;
        end else if (d_fin) begin
          d_st_q <= D_IDLE;
        end
        D_HELD: if (!intr) begin
          d_st_q <= UNIFIED ? D_WAIT_I : D_DPORT;
        end
        default: d_st_q <= D_IDLE;
      endcase
    end
  end

  // Completion pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_done_q <= 1'b0;
      d_done_q <= 1'b0;
    end else begin
      i_done_q <= i_fin && !rst_comb;
      d_done_q <= d_fin && !rst_comb;
    end
  end
  assign i_cdone = i_done_q;
  assign d_cdone = d_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane gathering of read words
  assign d_en = (d_on_i && iport_req.valid) || (d_on_d && !redir_now);

  csri_lane_cap u_icap (
    .pclk(pclk),
    .presetn(presetn),
    .clr(i_acc || i_ack),
    .en(i_on),
    .fin(i_fin),
    .be(iport_rsp.rbe),
    .din(iport_rsp.rdata),
    .dout(i_crdata)
  );

  csri_lane_cap u_dcap (
    .pclk(pclk),
    .presetn(presetn),
    .clr(d_acc || d_ack || redir_now),
    .en(d_en),
    .fin(d_fin),
    .be(d_on_i ? iport_rsp.rbe : dport_rsp.rbe),
    .din(d_on_i ? iport_rsp.rdata : dport_rsp.rdata),
    .dout(d_crdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_abort_cause: assert property (
    ((irq_in != 6'h00) || nmi_in) |-> (iport_abort == iport_req.valid) &&
      (dport_abort == dport_req.valid))
    else $error("abort not raised during pending transfer");

  a_stall_hold: assert property (
    (iport_req.valid && iport_rsp.stall && !ip_ack && !rst_comb)
      |=> iport_req.valid && $stable(iport_req.addr))
    else $error("stalled request not held");

  a_redirect_next: assert property (
    (redir_now && !i_on && !d_ack && !rst_comb)
      |=> iport_req.valid && d_on_i && !dport_req.valid)
    else $error("redirect not issued on fetch port next cycle");

  a_data_first: assert property (
    ((d_st_q == D_WAIT_I) && (i_st_q == I_WAIT) && !rst_comb)
      |=> (i_st_q != I_PORT))
    else $error("fetch granted over waiting data request");

  a_dual_parallel: assert property (
    ((!UNIFIED && i_acc && d_acc) ##1 (dport_rsp.stall && !redir_now && !d_ack && !rst_comb))
      |=> (i_on && d_on_d))
    else $error("dual ports not served in parallel");

  a_reset_falls: assert property (
    (rst_comb [*5] ##1 !rst_comb) |=> reset_exception_out)
    else $error("reset exception missing after falling edge");

  a_warm_unmasked: assert property (
    (cold_reset_in || (warm_reset_in && !debug_mode_out)) |-> rst_comb)
    else $error("reset masked outside debug mode");

  a_soft_flag: assert property (
    (exc_d && !cold_seen_q) |=> status_q[`CSRI_SR_BIT] && reset_exception_out)
    else $error("soft reset flag not set by warm reset");

  a_sleep_wake: assert property (
    (sleep_out && intr) |=> !sleep_out ##0 !$past(i_cready))
    else $error("sleep not left on interrupt");

  a_abort_retry: assert property (
    (i_ack && !rst_comb) |=> (i_st_q == I_HELD) && !i_cdone)
    else $error("aborted fetch reported as done");

  c_redirect: cover property (redir_now ##1 d_on_i ##[1:8] d_cdone);
  c_abort_ack: cover property (dp_ack ##[1:20] d_cdone);
  c_same_cycle: cover property (i_acc && d_acc);
  c_reset_exc: cover property (reset_exception_out && status_q[`CSRI_SR_BIT]);

endmodule
`default_nettype wire
